// ### hdl/slot_ctrl_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the
//          per-slot control and status registers
// Assumes: byte-wide registers in short address space
// Notes: definitions only
`ifndef SLOT_CTRL_MAP_SVH
`define SLOT_CTRL_MAP_SVH

// register offsets from the short-address base
`define SLOT_A_CTRL_OFFSET 8'h00
`define SLOT_B_CTRL_OFFSET 8'h01
`define SLOT_C_CTRL_OFFSET 8'h02
`define SLOT_D_CTRL_OFFSET 8'h03
`define SLOT_COUNT 4

// field positions
`define RESET_REQ_BIT 7
`define FAULT_BIT 2
`define IRQ_ONE_BIT 1
`define IRQ_ZERO_BIT 0

// reset value of every control register
`define CTRL_RESET_VALUE 8'h00

// module reset pulse length
`define MOD_RESET_TIME_NS 200
`define CLK_PERIOD_NS 25
`define MOD_RESET_CYCLES \
  ((`MOD_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hdl/slot_ctrl_pkg.sv
// Purpose: types shared by the slot control bank
// Assumes: nothing
// Notes: constants live in slot_ctrl_map.svh
package slot_ctrl_pkg;

  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_BUSY = 1'b1
  } rst_state_t;

  typedef struct packed {
    logic irqZero;
    logic irqOne;
    logic fault;
  } module_status_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### hdl/slot_reset_seq.sv
// Purpose: one slot's module reset sequencer and status synchroniser
// Assumes: module lines are asynchronous, active low at the pin
// Notes: reset-request bit is the busy state itself
`timescale 1ns/1ps
`include "slot_ctrl_map.svh"

module slot_reset_seq (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic startReset,
  input wire logic errorPin_n,
  input wire logic irqZeroPin_n,
  input wire logic irqOnePin_n,
  output logic moduleReset_n,
  output logic resetBusy,
  output slot_ctrl_pkg::module_status_t status
);

  localparam logic [3:0] RESET_LEN = 4'(`MOD_RESET_CYCLES);

  typedef struct packed {
    slot_ctrl_pkg::rst_state_t st;
    logic [3:0] cnt;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic rstOut_n;
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.syncA = {irqOnePin_n, irqZeroPin_n, errorPin_n};
    next_s.syncB = s.syncA;
    unique case (s.st)
      slot_ctrl_pkg::RST_IDLE: begin
        if (startReset) begin
          next_s.st = slot_ctrl_pkg::RST_BUSY;
          next_s.cnt = RESET_LEN;
          next_s.rstOut_n = 1'b0;
        end
      end
      slot_ctrl_pkg::RST_BUSY: begin
        if (s.cnt == 4'h1) begin
          next_s.st = slot_ctrl_pkg::RST_IDLE;
          next_s.rstOut_n = 1'b1;
          next_s.cnt = 4'h0;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // pins idle high, so the synchroniser resets to the idle level
      s <= '{st: slot_ctrl_pkg::RST_IDLE, cnt: 4'h0, syncA: 3'h7,
             syncB: 3'h7, rstOut_n: 1'b1};
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign moduleReset_n = s.rstOut_n;
  assign resetBusy = (s.st == slot_ctrl_pkg::RST_BUSY);
  assign status.fault = ~s.syncB[0];
  assign status.irqOne = ~s.syncB[2];
  assign status.irqZero = ~s.syncB[1];

endmodule // slot_reset_seq

// ### hdl/module_slot_control_status.sv
// Purpose: per-slot control and status registers, four module slots
// Assumes: register port is already decoded to short space and synchronous
// Notes: reads return one cycle after the request; reserved bits read 0
`timescale 1ns/1ps
`include "slot_ctrl_map.svh"

// Summary of operation
// - writing bit 7 starts module reset
// - bit 7 holds during reset, self-clears
// - bit 7 reads back live reset status
// - bit 2 mirrors module error, read-only
// - bits 1:0 show interrupt lines pending
// - slot C register at offset 0x02
// - strobe line is uncommitted input/output
// - four slot registers in short space
module module_slot_control_status (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire slot_ctrl_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [3:0] errorPin_n,
  input wire logic [3:0] irqZeroPin_n,
  input wire logic [3:0] irqOnePin_n,
  output logic [3:0] moduleReset_n,
  input wire logic [3:0] strobeIn,
  output logic [3:0] strobeOut,
  output logic [3:0] strobeOe,
  input wire logic [3:0] strobeDrive,
  input wire logic [3:0] strobeValue,
  output logic [3:0] strobeSeen
);

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] strobeOut;
    logic [3:0] strobeOe;
    logic [3:0] strobeMeta;
    logic [3:0] strobeSync;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  logic [3:0] resetBusy;
  logic [3:0] startReset;
  slot_ctrl_pkg::module_status_t [3:0] status;

  // slot index of an offset, or 4 for an unmapped one
  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    unique case (addr)
      `SLOT_A_CTRL_OFFSET: slot_of = 3'h0;
      `SLOT_B_CTRL_OFFSET: slot_of = 3'h1;
      `SLOT_C_CTRL_OFFSET: slot_of = 3'h2;
      `SLOT_D_CTRL_OFFSET: slot_of = 3'h3;
      default: slot_of = 3'h4;
    endcase
  endfunction

  function automatic logic [7:0] pack_reg(
    input logic busy,
    input slot_ctrl_pkg::module_status_t st
  );
    logic [7:0] v;
    v = `CTRL_RESET_VALUE;
    v[`RESET_REQ_BIT] = busy;
    v[`FAULT_BIT] = st.fault;
    v[`IRQ_ONE_BIT] = st.irqOne;
    v[`IRQ_ZERO_BIT] = st.irqZero;
    return v;
  endfunction

  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g++) begin : slot
      // only a 1 written to bit 7 starts; a 0 never aborts a running reset
      assign startReset[g] = req.sel && req.wr &&
        (slot_of(req.addr) == 3'(g)) && req.wdata[`RESET_REQ_BIT];
      slot_reset_seq seq (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .startReset(startReset[g]),
        .errorPin_n(errorPin_n[g]),
        .irqZeroPin_n(irqZeroPin_n[g]),
        .irqOnePin_n(irqOnePin_n[g]),
        .moduleReset_n(moduleReset_n[g]),
        .resetBusy(resetBusy[g]),
        .status(status[g])
      );
    end
  endgenerate

  always_comb begin
    logic [2:0] idx;
    idx = slot_of(req.addr);
    next_s = s;
    next_s.rvalid = req.sel && !req.wr;
    if (req.sel && !req.wr) begin
      if (idx[2]) begin
        next_s.rdata = 8'h00;
      end else begin
        next_s.rdata = pack_reg(resetBusy[idx[1:0]],
                                status[idx[1:0]]);
      end
    end
    // strobe is uncommitted: the system decides the direction per slot
    next_s.strobeOe = strobeDrive;
    next_s.strobeOut = strobeValue;
    next_s.strobeMeta = strobeIn;
    next_s.strobeSync = s.strobeMeta;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign rvalid = s.rvalid;
  assign strobeOut = s.strobeOut;
  assign strobeOe = s.strobeOe;
  assign strobeSeen = s.strobeSync;

endmodule // module_slot_control_status

// ### verif/slot_ctrl_chk.sv
// Purpose: port checks of the slot control bank
// Assumes: clkEn high around every read and slot C reset
// Notes: bound below
`timescale 1ns/1ps
module slot_ctrl_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire slot_ctrl_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [3:0] errorPin_n,
  input wire logic [3:0] irqZeroPin_n,
  input wire logic [3:0] moduleReset_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rd = req.sel && !req.wr;
  wire wrGo = req.sel && req.wr && req.wdata[7];
  AST_START: assert property (
    wrGo && req.addr == 8'h02 && moduleReset_n[2] |=> !moduleReset_n[2])
    else $error("slot C reset did not start");
  AST_HOLD: assert property (
    $fell(moduleReset_n[2]) |->
    !moduleReset_n[2] [*8] ##1 moduleReset_n[2])
    else $error("slot C reset pulse length wrong");
  AST_LIVE: assert property (
    rd && req.addr == 8'h02 |=>
    rvalid && rdata[7] == !$past(moduleReset_n[2]))
    else $error("busy bit not live");
  // a pin reaches the read data from the edge two before the read
  AST_FAULT: assert property (
    rd && req.addr == 8'h02 && !$past(rst) && !$past(rst, 2) |=>
    rdata[2] == !$past(errorPin_n[2], 3))
    else $error("fault bit wrong");
  AST_IRQ: assert property (
    rd && req.addr == 8'h03 && !$past(rst) && !$past(rst, 2) |=>
    rdata[0] == !$past(irqZeroPin_n[3], 3))
    else $error("irq line zero bit wrong");
  AST_MAP: assert property (
    rd && req.addr > 8'h03 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ONLY: assert property (
    wrGo && req.addr == 8'h02 && moduleReset_n[3] |=> moduleReset_n[3])
    else $error("write to slot C started slot D");
  AST_WRQ: assert property (
    req.sel && req.wr |=> !rvalid)
    else $error("write answered");
endmodule // slot_ctrl_chk
bind module_slot_control_status slot_ctrl_chk chk (.core_clk(core_clk),
  .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .errorPin_n(errorPin_n), .irqZeroPin_n(irqZeroPin_n),
  .moduleReset_n(moduleReset_n));

// ### verif/slot_module_model.sv
// Purpose: modules in the four slots
// Assumes: lvl is active high
// Notes: lines held, never left floating
`timescale 1ns/1ps
module slot_module_model (
  input wire logic [15:0] lvl,
  output logic [3:0] err,
  output logic [3:0] irqO,
  output logic [3:0] irqZ,
  output logic [3:0] stb
);
  assign err = ~lvl[3:0];
  assign irqO = ~lvl[7:4];
  assign irqZ = ~lvl[11:8];
  assign stb = lvl[15:12];
endmodule // slot_module_model

// ### verif/module_slot_control_status_tb.sv
// Purpose: bench of the slot control bank
// Assumes: clkEn low only in the freeze scenario
// Notes: reads queued, checked on rvalid
`timescale 1ns/1ps
module module_slot_control_status_tb;
  logic core_clk, rst, rvalid, en;
  logic [15:0] lvl;
  logic [3:0] drv, val, seen, so, soe, e, o, z, s, mr;
  logic [7:0] rdata, i, k, q[$];
  slot_ctrl_pkg::reg_req_t req;
  int num_errors, comparisons, cyc;
  slot_module_model m (.lvl(lvl), .err(e), .irqO(o), .irqZ(z), .stb(s));
  module_slot_control_status uut (.core_clk(core_clk), .rst(rst),
    .clkEn(en), .req(req), .rdata(rdata), .rvalid(rvalid),
    .errorPin_n(e), .irqZeroPin_n(z), .irqOnePin_n(o), .moduleReset_n(mr),
    .strobeIn(s), .strobeOut(so), .strobeOe(soe), .strobeDrive(drv),
    .strobeValue(val), .strobeSeen(seen));
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] sn, ex);
    comparisons++;
    if (sn !== ex) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, ex, sn);
    end
  endtask
  task final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function logic [7:0] st(input logic [7:0] n);
    return {5'h00, lvl[n], lvl[4+n], lvl[8+n]};
  endfunction
  task acc(input logic w, input logic [7:0] a, d, x);
    @(posedge core_clk);
    req <= '{1'b1, w, a, d};
    if (!w) q.push_back(x);
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk) req.sel <= 1'b0;
  endtask
  always @(negedge core_clk) if (rvalid === 1'b1) begin
    if (q.size() == 0) chk("spare rvalid", 8'h01, 8'h00);
    else chk("rdata", rdata, q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    en = 1'b1;
    req = '0;
    lvl = '0;
    drv = '0;
    val = '0;
    void'($urandom(32'hD7411FEC));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) acc(1'b0, i, 8'h00, 8'h00);
    repeat (3) begin
      idle(1);
      lvl <= 16'($urandom);
      drv <= 4'($urandom);
      val <= 4'($urandom);
      idle(4);
      for (i = 0; i < 4; i++) acc(1'b0, i, 8'h00, st(i));
    end
    for (i = 0; i < 4; i++) begin
      acc(1'b1, i, 8'h80, 8'h00);
      for (k = 1; k < 11; k++) begin
        // retrigger at k 3 must not stretch the pulse
        if (k == 3) acc(1'b1, i, 8'hFF, 8'h00);
        else acc(1'b0, i, 8'h00, {k < 9, 7'h00} | st(i));
        @(negedge core_clk);
        chk("mrst", {4'h0, mr},
            {4'h0, (k > 8) ? 4'hF : ~(4'h1 << i)});
      end
    end
    acc(1'b1, 8'h02, 8'h7F, 8'h00);
    k = 8'h04 + 8'($urandom % 252);
    acc(1'b1, k, 8'h80, 8'h00);
    acc(1'b0, k, 8'h00, 8'h00);
    for (i = 0; i < 4; i++) acc(1'b0, i, 8'h00, st(i));
    // five frozen edges in slot B's reset stretch its pulse by five
    acc(1'b1, 8'h01, 8'h80, 8'h00);
    for (k = 1; k < 16; k++) begin
      @(posedge core_clk);
      req.sel <= 1'b0;
      en <= (k < 2 || k > 6);
      @(negedge core_clk);
      chk("frozen", {7'h00, mr[1]}, {7'h00, k > 13});
    end
    idle(4);
    @(negedge core_clk);
    chk("seen", {4'h0, seen}, {4'h0, lvl[15:12]});
    chk("oe", {soe, so}, {drv, val});
    chk("left", 8'(q.size()), 8'h00);
    final_report;
  end
endmodule // module_slot_control_status_tb
